/* ddrsub_ctrl.sv */
/*
 * DRAM subsystem control: configuration registers, interrupt causes,
 * calibration start sequencing and the address-limit blocker, reached
 * over an APB slave.
 * Assumes boot software performs the clock, reset and PHY set-up steps
 * and that the PHY reports calibration completion on CAL_DONE_IN.
 */
// Notes on behaviour
// - Burst code at bits 18:16, resets to 2; 1,2,3 mean 1,2,4 beats.
// - Bit 0 of rmw register enables optimised read-modify-write; resets 0.
// - Bit 16 disables read interleave; software must set it.
// - Cause bit 7 rises on a command channel error; resets 0.
// - Cause bit 8 rises when calibration and training complete.
// - 32-bit mask, one bit per cause, set bit suppresses; resets 0.
// - DRAM appears from the given base; accesses forwarded to memory.
// - Writing 1 to start begins calibration and training.
// - Enable 0xF at bits 59:56 with top word address enables accesses.
// - Blocker set once after reset; rejects accesses beyond attached DRAM.
// - Start field is bit 0 of control register 0, resets to zero.
`include "ddrsub_cfg.svh"

module ddrsub_ctrl
(
    // Clock, reset, enable
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic CE_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [31:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Controller events and configuration
    input wire logic CMD_ERR_IN,
    input wire logic CAL_DONE_IN,
    output logic CAL_START_OUT,
    output logic [2:0] BSTLEN_OUT,
    output logic [3:0] BURST_BEATS_OUT,
    output logic RMW_OPT_OUT,
    output logic RD_INTLV_DIS_OUT,
    output logic IRQ_OUT,
    // Memory access gate
    input wire logic MEM_REQ_IN,
    input wire logic [37:0] MEM_ADDR_IN,
    output logic MEM_FWD_OUT,
    output logic [37:0] MEM_FWD_ADDR_OUT,
    output logic MEM_ERR_OUT
);
    import ddrsub_pkg::*;

    localparam ddrsub_state_s RST_STATE = '{
        bstlen: `DDRSUB_BSTLEN_RST,
        beats: 4'h2,
        rmw: 1'b0,
        intlv_dis: 1'b0,
        start: 1'b0,
        dram_class: 4'h0,
        status: 32'h0,
        mask: 32'h0,
        blk_addr: 54'h0,
        blk_en: 4'h0,
        blk_lock: 1'b0,
        cal: CAL_IDLE,
        cal_start: 1'b0,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h0,
        irq: 1'b0,
        fwd: 1'b0,
        fwd_addr: 38'h0,
        err: 1'b0
    };

    ddrsub_state_s q;
    ddrsub_state_s next_q;

    logic apb_done;
    logic wr;
    logic blk_on;
    logic init_done;
    logic in_window;
    logic below_limit;
    logic [31:0] rd_val;
    logic rd_hit;

    assign apb_done = PSEL_IN && PENABLE_IN && q.pready;
    assign wr = apb_done && PWRITE_IN;
    assign blk_on = (q.blk_en == `DDRSUB_BLK_EN_VAL);
    assign init_done = q.status[`DDRSUB_INIT_DONE_BIT];
    assign in_window = (MEM_ADDR_IN >= `DDRSUB_DRAM_BASE)
        && (MEM_ADDR_IN <= `DDRSUB_DRAM_TOP);
    assign below_limit = ({18'h0, MEM_ADDR_IN[37:2]} <= q.blk_addr);

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    always_comb
    begin
        rd_val = 32'h0;
        rd_hit = 1'b1;
        unique case (PADDR_IN)
            `DDRSUB_CTRL0_ADDR:
            begin
                rd_val[`DDRSUB_START_BIT] = q.start;
                rd_val[`DDRSUB_CLASS_LSB +: 4] = q.dram_class;
            end
            `DDRSUB_BSTLEN_ADDR:
                rd_val[`DDRSUB_BSTLEN_LSB +: 3] = q.bstlen;
            `DDRSUB_RMW_ADDR:
                rd_val[`DDRSUB_RMW_BIT] = q.rmw;
            `DDRSUB_INTLV_ADDR:
                rd_val[`DDRSUB_INTLV_BIT] = q.intlv_dis;
            `DDRSUB_STATUS_ADDR:
                rd_val = q.status;
            `DDRSUB_MASK_ADDR:
                rd_val = q.mask;
            `DDRSUB_BLK_LO_ADDR:
                rd_val = q.blk_addr[31:0];
            `DDRSUB_BLK_HI_ADDR:
            begin
                rd_val[21:0] = q.blk_addr[53:32];
                rd_val[`DDRSUB_BLK_EN_LSB +: 4] = q.blk_en;
            end
            default:
                rd_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_q = q;
        // One wait state, then the access completes
        next_q.pready = PSEL_IN && PENABLE_IN && !q.pready;
        next_q.pslverr = PSEL_IN && PENABLE_IN && !q.pready && !rd_hit;
        next_q.prdata = (PSEL_IN && PENABLE_IN && !q.pready && !PWRITE_IN)
            ? rd_val : 32'h0;

        if (wr)
        begin
            unique case (PADDR_IN)
                `DDRSUB_CTRL0_ADDR:
                begin
                    next_q.start = PWDATA_IN[`DDRSUB_START_BIT];
                    next_q.dram_class = PWDATA_IN[`DDRSUB_CLASS_LSB +: 4];
                end
                `DDRSUB_BSTLEN_ADDR:
                    next_q.bstlen = PWDATA_IN[`DDRSUB_BSTLEN_LSB +: 3];
                `DDRSUB_RMW_ADDR:
                    next_q.rmw = PWDATA_IN[`DDRSUB_RMW_BIT];
                `DDRSUB_INTLV_ADDR:
                    next_q.intlv_dis = PWDATA_IN[`DDRSUB_INTLV_BIT];
                `DDRSUB_MASK_ADDR:
                    next_q.mask = PWDATA_IN;
                `DDRSUB_BLK_LO_ADDR:
                begin
                    if (!q.blk_lock)
                        next_q.blk_addr[31:0] = PWDATA_IN;
                end
                `DDRSUB_BLK_HI_ADDR:
                begin
                    // Enable field may be set only once after reset
                    if (!q.blk_lock)
                    begin
                        next_q.blk_addr[53:32] = PWDATA_IN[21:0];
                        next_q.blk_en = PWDATA_IN[`DDRSUB_BLK_EN_LSB +: 4];
                        next_q.blk_lock = (PWDATA_IN[`DDRSUB_BLK_EN_LSB +: 4]
                            == `DDRSUB_BLK_EN_VAL);
                    end
                end
                default:
                begin
                end
            endcase
        end

        // Burst code decode
        unique case (next_q.bstlen)
            `DDRSUB_BSTLEN_BL1: next_q.beats = 4'h1;
            `DDRSUB_BSTLEN_BL2: next_q.beats = 4'h2;
            `DDRSUB_BSTLEN_BL4: next_q.beats = 4'h4;
            default: next_q.beats = 4'h0;
        endcase

        // Calibration sequencing
        unique case (q.cal)
            CAL_IDLE:
            begin
                if (wr && PADDR_IN == `DDRSUB_CTRL0_ADDR
                    && PWDATA_IN[`DDRSUB_START_BIT])
                    next_q.cal = CAL_RUN;
            end
            CAL_RUN:
            begin
                if (CAL_DONE_IN)
                begin
                    next_q.cal = CAL_DONE;
                    next_q.status[`DDRSUB_INIT_DONE_BIT] = 1'b1;
                end
            end
            CAL_DONE:
            begin
            end
            default:
                next_q.cal = CAL_IDLE;
        endcase
        next_q.cal_start = (next_q.cal == CAL_RUN);

        if (CMD_ERR_IN)
            next_q.status[`DDRSUB_CMD_ERR_BIT] = 1'b1;
        next_q.irq = |(next_q.status & ~next_q.mask);

        // Memory access gate
        next_q.fwd = MEM_REQ_IN && in_window && init_done && blk_on
            && below_limit;
        next_q.err = MEM_REQ_IN && !next_q.fwd;
        next_q.fwd_addr = next_q.fwd ? MEM_ADDR_IN : q.fwd_addr;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
            q <= RST_STATE;
        else if (CE_IN)
            q <= next_q;
    end

    assign PRDATA_OUT = q.prdata;
    assign PREADY_OUT = q.pready;
    assign PSLVERR_OUT = q.pslverr;
    assign CAL_START_OUT = q.cal_start;
    assign BSTLEN_OUT = q.bstlen;
    assign BURST_BEATS_OUT = q.beats;
    assign RMW_OPT_OUT = q.rmw;
    assign RD_INTLV_DIS_OUT = q.intlv_dis;
    assign IRQ_OUT = q.irq;
    assign MEM_FWD_OUT = q.fwd;
    assign MEM_FWD_ADDR_OUT = q.fwd_addr;
    assign MEM_ERR_OUT = q.err;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);

    burst_code_a: assert property (CE_IN && wr
        && PADDR_IN == `DDRSUB_BSTLEN_ADDR |=> BSTLEN_OUT
        == $past(PWDATA_IN[18:16]))
        else $error("burst code not stored");
    rmw_enable_a: assert property (CE_IN && wr
        && PADDR_IN == `DDRSUB_RMW_ADDR |=> RMW_OPT_OUT == $past(PWDATA_IN[0]))
        else $error("rmw enable not stored");
    intlv_disable_a: assert property (CE_IN && wr
        && PADDR_IN == `DDRSUB_INTLV_ADDR
        |=> RD_INTLV_DIS_OUT == $past(PWDATA_IN[16]))
        else $error("interleave disable not stored");
    cmd_error_a: assert property (CE_IN && CMD_ERR_IN
        |=> q.status[7] [*2])
        else $error("command error flag not sticky");
    init_done_a: assert property (CE_IN && q.cal == CAL_RUN
        && CAL_DONE_IN |=> q.status[8] && !CAL_START_OUT)
        else $error("init done flag missing");
    mask_store_a: assert property (CE_IN && wr
        && PADDR_IN == `DDRSUB_MASK_ADDR |=> q.mask == $past(PWDATA_IN))
        else $error("mask not stored");
    start_calib_a: assert property (CE_IN && wr && q.cal == CAL_IDLE
        && PADDR_IN == `DDRSUB_CTRL0_ADDR && PWDATA_IN[0]
        |=> CAL_START_OUT && q.start)
        else $error("calibration did not start");
    blocker_once_a: assert property (blk_on |=> blk_on
        && $stable(q.blk_addr))
        else $error("blocker changed after enable");
    irq_level_a: assert property (IRQ_OUT == |(q.status & ~q.mask))
        else $error("interrupt level wrong");
    gate_closed_a: assert property ($rose(MEM_FWD_OUT)
        |-> $past(init_done && blk_on))
        else $error("access forwarded before enable");
    window_reject_a: assert property (CE_IN && MEM_REQ_IN
        && MEM_ADDR_IN < `DDRSUB_DRAM_BASE |=> MEM_ERR_OUT && !MEM_FWD_OUT)
        else $error("access below base not rejected");
    rmw_hold_a: assert property (CE_IN
        && !(wr && PADDR_IN == `DDRSUB_RMW_ADDR)
        |=> $stable(RMW_OPT_OUT))
        else $error("rmw enable changed without write");
    beats_decode_a: assert property (BURST_BEATS_OUT ==
        ((BSTLEN_OUT == `DDRSUB_BSTLEN_BL1) ? 4'h1
        : (BSTLEN_OUT == `DDRSUB_BSTLEN_BL2) ? 4'h2
        : (BSTLEN_OUT == `DDRSUB_BSTLEN_BL4) ? 4'h4 : 4'h0))
        else $error("burst beats decode wrong");
    start_field_a: assert property (CE_IN && wr
        && PADDR_IN == `DDRSUB_CTRL0_ADDR
        |=> q.start == $past(PWDATA_IN[0]))
        else $error("start field not stored");
    blocker_store_a: assert property (CE_IN && wr && !q.blk_lock
        && PADDR_IN == `DDRSUB_BLK_HI_ADDR
        |=> q.blk_en == $past(PWDATA_IN[27:24]))
        else $error("blocker enable not stored");
    blocker_lock_a: assert property (CE_IN && wr && q.blk_lock
        && (PADDR_IN == `DDRSUB_BLK_LO_ADDR
        || PADDR_IN == `DDRSUB_BLK_HI_ADDR)
        |=> $stable(q.blk_addr) && $stable(q.blk_en))
        else $error("locked blocker was written");
    cal_once_a: assert property (CE_IN && q.cal == CAL_DONE
        |=> q.cal == CAL_DONE && !CAL_START_OUT)
        else $error("calibration restarted");
    status_bits_a: assert property (q.status[6:0] == 7'h0
        && q.status[31:9] == 23'h0)
        else $error("undefined cause flag set");
    done_source_a: assert property (CE_IN && q.cal != CAL_RUN
        |=> $stable(q.status[8]))
        else $error("init done flag set outside calibration");

    // ------------------------------------------------------------------
    // Checks on the memory gate
    // ------------------------------------------------------------------
    forward_addr_a: assert property (CE_IN && MEM_REQ_IN && in_window
        && init_done && blk_on && below_limit
        |=> MEM_FWD_OUT && MEM_FWD_ADDR_OUT == $past(MEM_ADDR_IN))
        else $error("access not forwarded");
    limit_reject_a: assert property (CE_IN && MEM_REQ_IN && !below_limit
        |=> MEM_ERR_OUT && !MEM_FWD_OUT)
        else $error("access beyond limit not rejected");
    gate_init_a: assert property (CE_IN && MEM_REQ_IN && !init_done
        |=> MEM_ERR_OUT && !MEM_FWD_OUT)
        else $error("access before init not rejected");

endmodule

/* ddrsub_cfg.svh */
/*
 * Offsets, field positions, reset values and decode constants of the
 * DRAM subsystem control block.
 * Assumes byte addresses on a 32-bit APB with one register per word.
 */
`ifndef DDRSUB_CFG_SVH
`define DDRSUB_CFG_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define DDRSUB_CTRL0_ADDR 32'h100b0000
`define DDRSUB_BSTLEN_ADDR 32'h100b004c
`define DDRSUB_RMW_ADDR 32'h100b0054
`define DDRSUB_INTLV_ADDR 32'h100b01e0
`define DDRSUB_STATUS_ADDR 32'h100b0210
`define DDRSUB_MASK_ADDR 32'h100b0220
`define DDRSUB_BLK_LO_ADDR 32'h100b8000
`define DDRSUB_BLK_HI_ADDR 32'h100b8004

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DDRSUB_START_BIT 0
`define DDRSUB_CLASS_LSB 8
`define DDRSUB_BSTLEN_LSB 16
`define DDRSUB_RMW_BIT 0
`define DDRSUB_INTLV_BIT 16
`define DDRSUB_CMD_ERR_BIT 7
`define DDRSUB_INIT_DONE_BIT 8
`define DDRSUB_BLK_EN_LSB 24

// ----------------------------------------------------------------------
// Reset and decode values
// ----------------------------------------------------------------------
`define DDRSUB_BSTLEN_RST 3'h2
`define DDRSUB_BSTLEN_BL1 3'h1
`define DDRSUB_BSTLEN_BL2 3'h2
`define DDRSUB_BSTLEN_BL4 3'h3
`define DDRSUB_BLK_EN_VAL 4'hf
`define DDRSUB_DRAM_BASE 38'h0080000000
`define DDRSUB_DRAM_TOP 38'h1f7fffffff

`endif

/* ddrsub_pkg.sv */
/*
 * Types of the DRAM subsystem control block.
 * Assumes nothing beyond the constants header.
 */
package ddrsub_pkg;

    typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_DONE} ddrsub_cal_e;

    typedef struct packed {
        logic [2:0] bstlen;
        logic [3:0] beats;
        logic rmw;
        logic intlv_dis;
        logic start;
        logic [3:0] dram_class;
        logic [31:0] status;
        logic [31:0] mask;
        logic [53:0] blk_addr;
        logic [3:0] blk_en;
        logic blk_lock;
        ddrsub_cal_e cal;
        logic cal_start;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
        logic fwd;
        logic [37:0] fwd_addr;
        logic err;
    } ddrsub_state_s;

endpackage

/* ddrsub_phy_model.sv */
/*
 * Behavioural model of the PHY and memory side of the DRAM subsystem
 * control block: calibration completion and command channel errors.
 * Assumes the bench asks for command errors and that a calibration
 * length in cycles is given as a parameter.
 */
module ddrsub_phy_model
#(
    parameter int CAL_CYCLES = 8
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Controller side
    input wire logic cal_start_in,
    input wire logic err_req_in,
    output logic cal_done_out,
    output logic cmd_err_out
);
    timeunit 1ns;
    timeprecision 100ps;

    int cnt;

    // ------------------------------------------------------------------
    // Calibration runs only while the controller requests it
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cnt <= 0;
            cal_done_out <= 1'b0;
            cmd_err_out <= 1'b0;
        end
        else
        begin
            cmd_err_out <= err_req_in;
            cnt <= cal_start_in ? cnt + 1 : 0;
            cal_done_out <= cal_start_in && !cal_done_out
                && (cnt == CAL_CYCLES - 1);
        end
    end
endmodule

/* ddrsub_ctrl_tb.sv */
/*
 * Self-checking bench of the DRAM subsystem control block: APB master
 * tasks, boot sequence, interrupt causes and the address blocker.
 * Assumes the PHY model file and the design files are compiled first.
 */
`include "ddrsub_cfg.svh"

module ddrsub_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ddrsub_pkg::*;

    logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, mem_req = 1'b0, err_req = 1'b0;
    logic ce = 1'b1;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic [37:0] mem_addr = 38'h0, fwd_addr;
    logic pready, pslverr, cmd_err, cal_done, cal_start, rmw, intlv, irq;
    logic fwd, merr;
    logic [2:0] bstlen;
    logic [3:0] beats;
    logic [31:0] v;
    logic e;
    int miscompares = 0;
    int checks = 0;
    int n;

    always #12.5 clk = ~clk;

    ddrsub_ctrl DUT (.CLK_IN(clk), .ARST_N_IN(arst_n), .CE_IN(ce),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .CMD_ERR_IN(cmd_err),
        .CAL_DONE_IN(cal_done), .CAL_START_OUT(cal_start),
        .BSTLEN_OUT(bstlen), .BURST_BEATS_OUT(beats), .RMW_OPT_OUT(rmw),
        .RD_INTLV_DIS_OUT(intlv), .IRQ_OUT(irq), .MEM_REQ_IN(mem_req),
        .MEM_ADDR_IN(mem_addr), .MEM_FWD_OUT(fwd),
        .MEM_FWD_ADDR_OUT(fwd_addr), .MEM_ERR_OUT(merr));

    ddrsub_phy_model #(.CAL_CYCLES(12)) phy (.clk_in(clk),
        .arst_n_in(arst_n), .cal_start_in(cal_start), .err_req_in(err_req),
        .cal_done_out(cal_done), .cmd_err_out(cmd_err));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("miscompares %0d checks %0d", miscompares, checks);
        if (miscompares == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [37:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [31:0] a, d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (k == 20)
        begin
            miscompares++;
            finish_test();
        end
        v = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [31:0] a, exp, input string name);
        apb(1'b0, a, 32'h0);
        chk(name, 38'(v), 38'(exp));
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic mem(input logic [37:0] a, input logic ok);
        @(posedge clk);
        mem_req <= 1'b1;
        mem_addr <= a;
        @(posedge clk);
        mem_req <= 1'b0;
        #1;
        chk("fwd_err", 38'({fwd, merr}), 38'({ok, !ok}));
        if (ok)
            chk("fwd_addr", fwd_addr, a);
    endtask

    // ------------------------------------------------------------------
    // Boot sequence and checks
    // ------------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        chk("bstlen_out", 38'(bstlen), 38'h2);
        chk("beats_out", 38'(beats), 38'h2);
        repeat (256) @(posedge clk);
        rd(`DDRSUB_CTRL0_ADDR, 32'h0, "ctrl0");
        rd(`DDRSUB_BSTLEN_ADDR, 32'h0002_0000, "bstlen");
        rd(`DDRSUB_RMW_ADDR, 32'h0, "rmw");
        rd(`DDRSUB_INTLV_ADDR, 32'h0, "intlv");
        rd(`DDRSUB_STATUS_ADDR, 32'h0, "status");
        rd(`DDRSUB_MASK_ADDR, 32'h0, "mask");
        rd(32'h100b0004, 32'h0, "unmapped");
        chk("slverr", 38'(e), 38'h1);
        wr(`DDRSUB_STATUS_ADDR, 32'hffff_ffff);
        rd(`DDRSUB_STATUS_ADDR, 32'h0, "status_ro");
        mem(38'h00_8000_0000, 1'b0);
        wr(`DDRSUB_RMW_ADDR, 32'h1);
        settle();
        chk("rmw_out", 38'(rmw), 38'h1);
        wr(`DDRSUB_INTLV_ADDR, 32'h0001_0000);
        settle();
        chk("intlv_out", 38'(intlv), 38'h1);
        wr(`DDRSUB_CTRL0_ADDR, 32'h0000_0600);
        rd(`DDRSUB_CTRL0_ADDR, 32'h0000_0600, "ctrl0_cfg");
        chk("cal_held", 38'(cal_start), 38'h0);
        @(posedge clk);
        err_req <= 1'b1;
        @(posedge clk);
        err_req <= 1'b0;
        settle();
        rd(`DDRSUB_STATUS_ADDR, 32'h80, "cmd_err");
        chk("irq_cmd", 38'(irq), 38'h1);
        wr(32'h100b_5200, 32'h0);
        wr(32'h100b_4000, 32'h0);
        for (n = 0; n < 4; n++)
        begin
            wr(`DDRSUB_BSTLEN_ADDR, 32'(n) << 16);
            settle();
            chk("bstlen_code", 38'(bstlen), 38'(n));
            chk("beats", 38'(beats), 38'(n == 0 ? 0 : 1 << (n - 1)));
        end
        wr(`DDRSUB_MASK_ADDR, 32'hffff_ffff);
        settle();
        chk("irq_masked", 38'(irq), 38'h0);
        rd(`DDRSUB_MASK_ADDR, 32'hffff_ffff, "mask");
        wr(`DDRSUB_CTRL0_ADDR, 32'h0000_0601);
        #1;
        chk("cal_start", 38'(cal_start), 38'h1);
        for (n = 0; n < 50; n++)
        begin
            apb(1'b0, `DDRSUB_STATUS_ADDR, 32'h0);
            if (v[8] === 1'b1)
                break;
        end
        chk("init_done", 38'(v), 38'h180);
        chk("cal_stop", 38'(cal_start), 38'h0);
        chk("irq_done_masked", 38'(irq), 38'h0);
        rd(`DDRSUB_CTRL0_ADDR, 32'h0000_0601, "ctrl0_start");
        wr(`DDRSUB_MASK_ADDR, 32'hffff_feff);
        settle();
        chk("irq_done", 38'(irq), 38'h1);
        mem(38'h00_8000_0000, 1'b0);
        wr(`DDRSUB_BLK_LO_ADDR, 32'h2000_03ff);
        wr(`DDRSUB_BLK_HI_ADDR, 32'h0f00_0000);
        mem(38'h00_8000_0000, 1'b1);
        mem(38'h00_8000_0ffc, 1'b1);
        mem(38'h00_8000_1000, 1'b0);
        mem(38'h00_7fff_fffc, 1'b0);
        wr(`DDRSUB_BLK_HI_ADDR, 32'h0);
        mem(38'h00_8000_0800, 1'b1);
        @(posedge clk);
        ce <= 1'b0;
        mem_req <= 1'b1;
        mem_addr <= 38'h00_8000_0000;
        @(posedge clk);
        ce <= 1'b1;
        mem_req <= 1'b0;
        #1;
        chk("ce_freeze", 38'({fwd, merr}), 38'h0);
        rd(`DDRSUB_BLK_HI_ADDR, 32'h0f00_0000, "blk_locked");
        rd(`DDRSUB_BLK_LO_ADDR, 32'h2000_03ff, "blk_lo");
        finish_test();
    end
endmodule
